// ==== design/gtc_pkg.sv ====
// Package: constants and carrier types for the transmit clocking and phase FIFO block
package gtc_pkg;
	// Reference clock choices, in kHz
	localparam int REF_KHZ_LOW        = 62500;
	localparam int REF_KHZ_HIGH       = 125000;
	// Serial clock and its parallel division
	localparam int SERIAL_KHZ         = 625000;
	localparam int MULT_LOW_REF       = 10;
	localparam int MULT_HIGH_REF      = 5;
	localparam int LOCAL_DIV          = 5;
	localparam int PAR_KHZ            = SERIAL_KHZ / LOCAL_DIV;
	// System clock, used to pace the parallel enable
	localparam int SYS_KHZ            = 100000;
	// Phase FIFO depth and latency window in parallel cycles
	localparam int FIFO_DEPTH         = 4;
	localparam int LAT_MIN            = 2;
	localparam int LAT_MAX            = 3;
	// Widths
	localparam int DATA_W             = 8;
	localparam int CODE_W             = 10;
	// Reset values
	localparam logic [9:0] CODE_RST   = 10'h000;
	localparam logic [7:0] DATA_RST   = 8'h00;

	// Reference selection
	typedef enum logic [0:0]
	{
		GTC_REF_125  = 1'b0,
		GTC_REF_62P5 = 1'b1
	} gtc_ref_sel_t;

	// One transmit word: data byte plus control flag
	typedef struct packed
	{
		logic       ctrl;
		logic [7:0] data;
	} gtc_word_t;
endpackage : gtc_pkg

// ==== design/gtc_skid.sv ====
// Two-entry valid/ready buffer in front of the encoder output
`timescale 1ns/1ps
module gtc_skid #(
	parameter int W = 10
) (
	input  wire logic         i_clk_sys,
	input  wire logic         i_rst_n,
	input  wire logic [W-1:0] i_data,
	input  wire logic         i_valid,
	output logic              o_ready,
	output logic [W-1:0]      o_data,
	output logic              o_valid,
	input  wire logic         i_ready
);
	logic [W-1:0] mem [2];
	logic [W-1:0] next_mem [2];
	logic [1:0]   cnt;
	logic [1:0]   next_cnt;
	logic         rd;
	logic         next_rd;
	logic         push;
	logic         pop;

	assign o_ready = (cnt != 2'h2);
	assign o_valid = (cnt != 2'h0);
	assign o_data  = mem[rd];
	assign push    = i_valid && o_ready;
	assign pop     = o_valid && i_ready;

	// Next state of the two slots
	always_comb
	begin
		next_mem = mem;
		next_cnt = cnt;
		next_rd  = rd;
		if (push)
			next_mem[rd ^ cnt[0]] = i_data;
		if (pop)
			next_rd = ~rd;
		case ({push, pop})
			2'b10: next_cnt = cnt + 2'h1;
			2'b01: next_cnt = cnt - 2'h1;
			default: next_cnt = cnt;
		endcase
	end

	// Register
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			mem[0] <= '0;
			mem[1] <= '0;
			cnt    <= 2'h0;
			rd     <= 1'b0;
		end
		else
		begin
			mem <= next_mem;
			cnt <= next_cnt;
			rd  <= next_rd;
		end
	end
endmodule // gtc_skid

// ==== design/gtc_tx_chan.sv ====
// Transmit channel clocking model, phase FIFO and encoder entry
`timescale 1ns/1ps
module gtc_tx_chan #(
	parameter int DEPTH = gtc_pkg::FIFO_DEPTH
) (
	input  wire logic                 i_clk_sys,
	input  wire logic                 i_rst_n,
	input  wire gtc_pkg::gtc_ref_sel_t i_ref_sel,
	input  wire logic                 i_ser_tick,
	input  wire logic                 i_wr_tick_ext,
	input  wire logic                 i_wr_tick_used,
	input  wire gtc_pkg::gtc_word_t   i_word,
	input  wire logic                 i_word_valid,
	output logic                      o_word_ready,
	output logic                      o_par_tick,
	output logic                      o_ser_tick,
	output logic [3:0]                o_pll_mult,
	output logic [9:0]                o_code,
	output logic                      o_code_valid,
	input  wire logic                 i_code_ready
);
	localparam int AW = $clog2(DEPTH);

	// Stable multiplier for the chosen reference
	logic [3:0] next_mult;
	logic [3:0] mult;
	always_comb
	begin
		case (i_ref_sel)
			gtc_pkg::GTC_REF_62P5: next_mult = 4'(gtc_pkg::MULT_LOW_REF);
			default:               next_mult = 4'(gtc_pkg::MULT_HIGH_REF);
		endcase
	end

	// Local divider: one parallel tick per five serial ticks
	logic [2:0] div_cnt;
	logic [2:0] next_div_cnt;
	logic       next_par;
	always_comb
	begin
		next_div_cnt = div_cnt;
		next_par     = 1'b0;
		if (i_ser_tick)
		begin
			if (div_cnt == 3'(gtc_pkg::LOCAL_DIV - 1))
			begin
				next_div_cnt = 3'h0;
				next_par     = 1'b1;
			end
			else
				next_div_cnt = div_cnt + 3'h1;
		end
	end

	// Write tick: external when present, else our parallel tick
	logic wr_tick;
	assign wr_tick = i_wr_tick_used ? i_wr_tick_ext : o_par_tick;

	// Phase FIFO, four words, written per write tick, read per parallel tick
	gtc_pkg::gtc_word_t mem [DEPTH];
	gtc_pkg::gtc_word_t next_mem [DEPTH];
	logic [AW:0] wp, next_wp, rp, next_rp;
	logic [AW:0] fill;
	logic        wr_en, rd_en;
	gtc_pkg::gtc_word_t rd_word;
	logic        enc_ready;
	assign fill    = wp - rp;
	assign wr_en   = wr_tick && i_word_valid && (fill != (AW+1)'(DEPTH));
	// Read only while at least two words are held, giving two to three ticks of latency
	assign rd_en   = o_par_tick && (fill > (AW+1)'(1)) && enc_ready;
	assign rd_word = mem[rp[AW-1:0]];

	always_comb
	begin
		next_mem = mem;
		next_wp  = wp;
		next_rp  = rp;
		if (wr_en)
		begin
			next_mem[wp[AW-1:0]] = i_word;
			next_wp = wp + (AW+1)'(1);
		end
		if (rd_en)
			next_rp = rp + (AW+1)'(1);
	end

	// Simple encoder stand-in: control flag, 8b data, and a parity bit
	logic [9:0] enc_code;
	assign enc_code = {rd_word.ctrl, ^rd_word.data, rd_word.data};

	// Output buffer so that an encoder stall loses no word
	logic [9:0] sk_data;
	logic       sk_valid;
	gtc_skid #(.W(gtc_pkg::CODE_W)) u_skid (
		.i_clk_sys (i_clk_sys),
		.i_rst_n   (i_rst_n),
		.i_data    (enc_code),
		.i_valid   (rd_en),
		.o_ready   (enc_ready),
		.o_data    (sk_data),
		.o_valid   (sk_valid),
		.i_ready   (sk_pop)
	);

	// Output stage, registered for clean ports
	logic       next_code_valid;
	logic [9:0] next_code;
	logic       sk_pop;
	always_comb
	begin
		next_code_valid = o_code_valid;
		next_code       = o_code;
		// Take from the buffer exactly when the output register loads
		sk_pop          = !o_code_valid || i_code_ready;
		if (sk_pop)
		begin
			next_code_valid = sk_valid;
			next_code       = sk_data;
		end
	end

	// Register all state
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			mult         <= 4'(gtc_pkg::MULT_HIGH_REF);
			div_cnt      <= 3'h0;
			o_par_tick   <= 1'b0;
			o_ser_tick   <= 1'b0;
			o_pll_mult   <= 4'(gtc_pkg::MULT_HIGH_REF);
			wp           <= '0;
			rp           <= '0;
			o_word_ready <= 1'b0;
			o_code       <= gtc_pkg::CODE_RST;
			o_code_valid <= 1'b0;
			for (int k = 0; k < DEPTH; k++)
				mem[k] <= '0;
		end
		else
		begin
			mult         <= next_mult;
			o_pll_mult   <= mult;
			div_cnt      <= next_div_cnt;
			o_par_tick   <= next_par;
			o_ser_tick   <= i_ser_tick;
			wp           <= next_wp;
			rp           <= next_rp;
			mem          <= next_mem;
			o_word_ready <= ((next_wp - next_rp) != (AW+1)'(DEPTH));
			o_code       <= next_code;
			o_code_valid <= next_code_valid;
		end
	end
endmodule // gtc_tx_chan

// ==== testbench/gtc_asserts.sv ====
// Port checker for the transmit channel
`timescale 1ns/1ps
module gtc_chk (
	input wire logic                  i_clk_sys,
	input wire logic                  i_rst_n,
	input wire gtc_pkg::gtc_ref_sel_t i_ref_sel,
	input wire logic                  i_ser_tick,
	input wire logic                  i_code_ready,
	input wire logic                  o_par_tick,
	input wire logic                  o_ser_tick,
	input wire logic [3:0]            o_pll_mult,
	input wire logic [9:0]            o_code,
	input wire logic                  o_code_valid
);
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rst_n);
	// Clock tree relations
	ser_fwd_a: assert property (i_ser_tick |=> o_ser_tick) else $error("ser fwd");
	ser_idle_a: assert property (!i_ser_tick |=> !o_ser_tick) else $error("ser idle");
	par_gap_a: assert property (o_par_tick |=> !o_par_tick [*4]) else $error("par gap");
	par_cause_a: assert property (o_par_tick |-> $past(i_ser_tick)) else $error("par");
	mult_low_a: assert property ((i_ref_sel) [*3] |-> o_pll_mult == 4'ha) else $error("x10");
	mult_high_a: assert property ((!i_ref_sel) [*3] |-> o_pll_mult == 4'h5) else $error("x5");
	// Stalled code word holds
	hold_valid_a: assert property (o_code_valid && !i_code_ready |=> o_code_valid) else $error("v");
	hold_code_a: assert property (o_code_valid && !i_code_ready |=> $stable(o_code)) else $error("c");
endmodule // gtc_chk
bind gtc_tx_chan gtc_chk u_chk (.i_clk_sys, .i_rst_n, .i_ref_sel, .i_ser_tick, .i_code_ready,
	.o_par_tick, .o_ser_tick, .o_pll_mult, .o_code, .o_code_valid);

// ==== testbench/gtc_fab.sv ====
// Fabric model offering a counting word stream
`timescale 1ns/1ps
module gtc_fab (
	input  wire logic          i_clk_sys,
	input  wire logic          i_rst_n,
	input  wire logic          i_en,
	input  wire logic          i_tick,
	input  wire logic          i_ready,
	output gtc_pkg::gtc_word_t o_word,
	output logic               o_valid,
	output logic [7:0]         o_sent
);
	// Next word only once a write tick takes the current one
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
		if (!i_rst_n)
			o_sent <= 8'h00;
		else if (i_tick && o_valid && i_ready)
			o_sent <= o_sent + 8'h01;
	// Idle bus shows the inverted word
	assign o_valid = i_en;
	assign o_word = {o_sent[0], o_sent} ^ {9{!i_en}};
endmodule // gtc_fab

// ==== testbench/gtc_tx_chan_tb.sv ====
// Self-checking bench for the transmit channel
`timescale 1ns/1ps
module gtc_tx_chan_tb;
	logic                  clk, rst_n, ser, ext, used, en, crdy, wvld, wrdy, par, sert, cvld;
	gtc_pkg::gtc_ref_sel_t rsel;
	gtc_pkg::gtc_word_t    word;
	logic [3:0]            mult;
	logic [9:0]            code;
	logic [7:0]            sent;
	int                    n_mismatch, checks_done, rx, pars, phase;
	gtc_tx_chan DUT (.i_clk_sys(clk), .i_rst_n(rst_n), .i_ref_sel(rsel), .i_ser_tick(ser),
		.i_wr_tick_ext(ext), .i_wr_tick_used(used), .i_word(word), .i_word_valid(wvld),
		.o_word_ready(wrdy), .o_par_tick(par), .o_ser_tick(sert), .o_pll_mult(mult),
		.o_code(code), .o_code_valid(cvld), .i_code_ready(crdy));
	gtc_fab u_fab (.i_clk_sys(clk), .i_rst_n(rst_n), .i_en(en), .i_tick(used ? ext : par),
		.i_ready(wrdy), .o_word(word), .o_valid(wvld), .o_sent(sent));
	task automatic check(input logic [8:0] got, input logic [8:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_sim;
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic wait_rx(input int n);
		for (int i = 0; i < 3000 && rx < n; i++)
			@(posedge clk);
		if (rx < n)
		begin
			n_mismatch++;
			end_sim();
		end
	endtask
	// External write tick, same rate as the parallel tick, other phase
	always @(posedge clk)
	begin
		phase <= (phase == 4) ? 0 : phase + 1;
		ext <= (phase == 1);
		pars <= pars + int'(par);
		if (rst_n && cvld && crdy)
		begin
			check({code[9], code[7:0]}, {rx[0], rx[7:0]});
			check(9'(code[8]), 9'(^rx[7:0]));
			rx <= rx + 1;
		end
	end
	// Tick rates and multiplier setting
	task automatic s_clocks;
		int p;
		repeat (10) @(posedge clk);
		#1;
		p = pars;
		repeat (50) @(posedge clk);
		#1;
		check(9'(pars - p), 9'h00a);
		check(9'(sert), 9'h001);
		check(9'(mult), 9'h005);
		@(posedge clk);
		rsel <= gtc_pkg::GTC_REF_62P5;
		ser <= 1'b0;
		repeat (5) @(posedge clk);
		#1;
		check(9'(mult), 9'h00a);
		p = pars;
		repeat (10) @(posedge clk);
		#1;
		check(9'(pars - p), 9'h000);
		@(posedge clk);
		rsel <= gtc_pkg::GTC_REF_125;
		ser <= 1'b1;
	endtask
	// Words written by the parallel tick reach the encoder in order
	task automatic s_internal;
		en <= 1'b1;
		wait_rx(rx + 8);
		en <= 1'b0;
	endtask
	// Stalled consumer fills the path, then drains all but the last word
	task automatic s_full;
		logic [7:0] s;
		crdy <= 1'b0;
		used <= 1'b1;
		en <= 1'b1;
		for (int i = 0; i < 200 && wrdy !== 1'b0; i++)
			@(posedge clk);
		if (wrdy !== 1'b0)
		begin
			n_mismatch++;
			end_sim();
		end
		s = sent;
		repeat (20) @(posedge clk);
		check(9'(sent), 9'(s));
		check(9'(wrdy), 9'h000);
		en <= 1'b0;
		crdy <= 1'b1;
		wait_rx(int'(sent) - 1);
	endtask
	initial
	begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	initial
	begin
		{rst_n, ext, used, en, phase, pars, rx, n_mismatch, checks_done} = '0;
		rsel = gtc_pkg::GTC_REF_125;
		ser = 1'b1;
		crdy = 1'b1;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		s_clocks();
		s_internal();
		s_full();
		end_sim();
	end
endmodule // gtc_tx_chan_tb
